// ---- hw/acr_pkg.sv ----
// types shared by the audio crosspoint router
// assumes the constants header sits beside it
`include "acr_regs.svh"
package acr_pkg;
  typedef enum logic [1:0] {FB_MATRIX, FB_SINE, FB_MUTE, FB_DELETE} acr_fb_t;
  typedef enum logic [1:0] {SRC_OFF, SRC_ON, SRC_AUTO, SRC_AUTO_ALT} acr_src_t;
endpackage

// ---- hw/acr_regs.svh ----
// register offsets, field positions, reset values and timing counts of the audio crosspoint router
// assumes inclusion by bare name from the package and the design module
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
// ==========================================
// register byte offsets
`define ACR_OFF_AES_DIR 8'h00
`define ACR_OFF_SRC_MODE 8'h04
`define ACR_OFF_TRACK 8'h08
`define ACR_OFF_FALLBACK 8'h0c
`define ACR_OFF_SINE_LVL 8'h10
`define ACR_OFF_REL_DLY 8'h14
`define ACR_OFF_AES_DLY 8'h18
`define ACR_OFF_STATUS 8'h28
`define ACR_OFF_XSEL 8'h40
`define ACR_OFF_SHUF 8'h80
// ==========================================
// field positions
`define ACR_FB_AES_LSB 2
`define ACR_SHUF_R_LSB 5
`define ACR_ST_ERR_LSB 4
// ==========================================
// reset values
`define ACR_RST_DIR 4'h0
`define ACR_RST_SRC 8'haa
`define ACR_RST_XSEL 5'h0d
`define ACR_RST_SHUF 10'h000
// ==========================================
// sizes and timing
`define ACR_SW 24
`define ACR_DEPTH 32000
`define ACR_CLK_HZ 40000000
`define ACR_FS_HZ 48000
`define ACR_TICK_DIV (`ACR_CLK_HZ / `ACR_FS_HZ)
`define ACR_SINE_HZ 1000
`define ACR_SINE_LEN (`ACR_FS_HZ / `ACR_SINE_HZ)
`define ACR_GAP_MS 250
`define ACR_GAP_LEN (`ACR_GAP_MS * `ACR_FS_HZ / 1000)
`define ACR_CYCLE_S 3
`define ACR_CYCLE_LEN (`ACR_CYCLE_S * `ACR_FS_HZ)
`define ACR_LVL_18 16'h101d
`define ACR_LVL_20 16'h0ccd
`define ACR_PH_RD0 1
`define ACR_PH_CAP0 3
`define ACR_PH_OUT 8
`endif

// ---- hw/acr_router.sv ----
// audio crosspoint router: delays, mono shuffler, test tone, 18x13 stereo crosspoint, fallbacks
// assumes upstream audio sources and downstream embedder/transmitters run on pclk
//
// Overview of operation
// - all embedded channels are always captured; no disable exists
// - one signed relative delay applies alike to all extracted channels
// - video delay plus relative delay is limited to 32000 samples of store
// - negative delay beyond video delay cannot be met and flags an error
// - with sync present actual video delay lies between N and N+1 frames
// - eighteen sources: AES, extracted pairs, shufflers, 1 kHz tone, silence
// - thirteen destinations: eight embed pairs, four AES outputs, one data output
// - AES direction per port; an output port as source gives invalid audio
// - embed destinations share one fallback: matrix, tone, silence or delete
// - silence fallback sends valid zero samples
// - delete fallback removes audio and flags channels deleted for control packet
// - output-off fallback turns off that AES driver
// - each shuffler pair built from two freely chosen mono sources
// - four AES directions set independently, any split allowed
// - unsynchronous AES inputs pass through the rate converter
// - each AES input has its own delay before the crosspoint
// - track-to-video derives a locked AES input's delay from video and audio delays
// - converter modes on, off, auto; software avoids on with tracking
// - AES outputs run at 48 kHz on the system clock
// - each AES output has its own fallback choice
// - tone is 1 kHz, left muted 250 ms each 3 s, -18 or -20 dBFS
`timescale 1ns/1ps
`include "acr_regs.svh"
module acr_router import acr_pkg::*; #(
  parameter int DEPTH = `ACR_DEPTH,
  parameter int SW = `ACR_SW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // extracted audio and video delay
  input wire logic [16*SW-1:0] demb_data,
  input wire logic [7:0] demb_valid,
  input wire logic [15:0] video_delay,
  // aes receive side and rate converter
  input wire logic [4*SW-1:0] aes_in_l,
  input wire logic [4*SW-1:0] aes_in_r,
  input wire logic [3:0] aes_in_valid,
  input wire logic [3:0] aes_rate_sync,
  input wire logic [4*SW-1:0] aes_src_l,
  input wire logic [4*SW-1:0] aes_src_r,
  output logic [3:0] src_en,
  // embedder side
  output logic [8*SW-1:0] emb_l,
  output logic [8*SW-1:0] emb_r,
  output logic [7:0] emb_valid,
  output logic [7:0] emb_delete,
  // aes transmit side
  output logic [4*SW-1:0] aes_out_l,
  output logic [4*SW-1:0] aes_out_r,
  output logic [3:0] aes_out_valid,
  output logic [3:0] aes_oe,
  // data output and sample strobe
  output logic [SW-1:0] data_l,
  output logic [SW-1:0] data_r,
  output logic data_valid,
  output logic smp_strobe
);
  localparam int AW = $clog2(DEPTH);
  localparam int RW = 24 * SW + 12;
  localparam int NSRC = 18;
  localparam int NDST = 13;
  localparam logic [9:0] TICK_LAST = 10'(`ACR_TICK_DIV - 1);
  localparam logic [5:0] SINE_LAST = 6'(`ACR_SINE_LEN - 1);
  localparam logic [17:0] GAP_LEN = 18'(`ACR_GAP_LEN);
  localparam logic [17:0] CYC_LAST = 18'(`ACR_CYCLE_LEN - 1);

  // ==========================================
  // functions
  function automatic logic [16:0] clamp_d(input logic signed [17:0] v);
    if (v < 0) begin
      clamp_d = 17'h10000;
    end else if (v > $signed(18'(DEPTH - 1))) begin
      clamp_d = {1'b1, 16'(DEPTH - 1)};
    end else begin
      clamp_d = {1'b0, v[15:0]};
    end
  endfunction

  function automatic logic [AW-1:0] dly_addr(input logic [AW-1:0] w, input logic [15:0] d);
    logic [AW:0] t;
    t = {1'b0, w} + (AW+1)'(DEPTH) - {1'b0, d[AW-1:0]};
    if (w >= d[AW-1:0]) begin
      dly_addr = w - d[AW-1:0];
    end else begin
      dly_addr = t[AW-1:0];
    end
  endfunction

  function automatic logic signed [15:0] qsin(input logic [3:0] k);
    case (k)
      4'h0: qsin = 16'h0000;
      4'h1: qsin = 16'h10b5;
      4'h2: qsin = 16'h2121;
      4'h3: qsin = 16'h30fb;
      4'h4: qsin = 16'h4000;
      4'h5: qsin = 16'h4deb;
      4'h6: qsin = 16'h5a82;
      4'h7: qsin = 16'h658c;
      4'h8: qsin = 16'h6ed9;
      4'h9: qsin = 16'h7641;
      4'ha: qsin = 16'h7ba3;
      4'hb: qsin = 16'h7ee7;
      default: qsin = 16'h7fff;
    endcase
  endfunction

  // ==========================================
  // configuration registers and apb
  logic [3:0] aes_dir_reg, aes_dir_next;
  logic [7:0] src_mode_reg, src_mode_next;
  logic [3:0] track_reg, track_next;
  acr_fb_t emb_fb_reg, emb_fb_next;
  logic [7:0] aes_fb_reg, aes_fb_next;
  logic sine_lvl_reg, sine_lvl_next;
  logic [15:0] rel_dly_reg, rel_dly_next;
  logic [15:0] aes_dly_reg [4], aes_dly_next [4];
  logic [4:0] xsel_reg [NDST], xsel_next [NDST];
  logic [9:0] shuf_reg [4], shuf_next [4];
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [3:0] src_en_reg, src_en_next;
  logic [4:0] dly_err_reg, dly_err_next;
  logic [7:0] xo, so;
  logic hit, acc;

  always_comb begin
    aes_dir_next = aes_dir_reg;
    src_mode_next = src_mode_reg;
    track_next = track_reg;
    emb_fb_next = emb_fb_reg;
    aes_fb_next = aes_fb_reg;
    sine_lvl_next = sine_lvl_reg;
    rel_dly_next = rel_dly_reg;
    aes_dly_next = aes_dly_reg;
    xsel_next = xsel_reg;
    shuf_next = shuf_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    xo = paddr - `ACR_OFF_XSEL;
    so = paddr - `ACR_OFF_SHUF;
    acc = psel && penable && pready_reg;
    // no wait state: setup decodes, first access cycle completes
    pready_next = psel && !penable;
    hit = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr >= `ACR_OFF_XSEL && xo < 8'(4 * NDST)) begin
      hit = 1'b1;
    end else if (paddr >= `ACR_OFF_SHUF && so < 8'h10) begin
      hit = 1'b1;
    end else if (paddr >= `ACR_OFF_AES_DLY && paddr < `ACR_OFF_STATUS) begin
      hit = 1'b1;
    end else begin
      hit = paddr <= `ACR_OFF_REL_DLY || paddr == `ACR_OFF_STATUS;
    end
    if (psel && !penable) begin
      pslverr_next = !hit;
      prdata_next = 32'h0;
      if (paddr == `ACR_OFF_AES_DIR) prdata_next = {28'h0, aes_dir_reg};
      if (paddr == `ACR_OFF_SRC_MODE) prdata_next = {24'h0, src_mode_reg};
      if (paddr == `ACR_OFF_TRACK) prdata_next = {28'h0, track_reg};
      if (paddr == `ACR_OFF_FALLBACK) prdata_next = {22'h0, aes_fb_reg, emb_fb_reg};
      if (paddr == `ACR_OFF_SINE_LVL) prdata_next = {31'h0, sine_lvl_reg};
      if (paddr == `ACR_OFF_REL_DLY) prdata_next = {16'h0, rel_dly_reg};
      if (paddr == `ACR_OFF_STATUS) prdata_next = {23'h0, dly_err_reg, src_en_reg};
      for (int i = 0; i < 4; i++) begin
        if (paddr == `ACR_OFF_AES_DLY + 8'(4 * i)) prdata_next = {16'h0, aes_dly_reg[i]};
        if (paddr == `ACR_OFF_SHUF + 8'(4 * i)) prdata_next = {22'h0, shuf_reg[i]};
      end
      for (int i = 0; i < NDST; i++) begin
        if (paddr == `ACR_OFF_XSEL + 8'(4 * i)) prdata_next = {27'h0, xsel_reg[i]};
      end
    end
    if (acc && pwrite && hit) begin
      if (paddr == `ACR_OFF_AES_DIR) aes_dir_next = pwdata[3:0];
      if (paddr == `ACR_OFF_SRC_MODE) src_mode_next = pwdata[7:0];
      if (paddr == `ACR_OFF_TRACK) track_next = pwdata[3:0];
      if (paddr == `ACR_OFF_FALLBACK) begin
        emb_fb_next = acr_fb_t'(pwdata[1:0]);
        aes_fb_next = pwdata[`ACR_FB_AES_LSB +: 8];
      end
      if (paddr == `ACR_OFF_SINE_LVL) sine_lvl_next = pwdata[0];
      if (paddr == `ACR_OFF_REL_DLY) rel_dly_next = pwdata[15:0];
      for (int i = 0; i < 4; i++) begin
        if (paddr == `ACR_OFF_AES_DLY + 8'(4 * i)) aes_dly_next[i] = pwdata[15:0];
        if (paddr == `ACR_OFF_SHUF + 8'(4 * i)) shuf_next[i] = pwdata[9:0];
      end
      for (int i = 0; i < NDST; i++) begin
        if (paddr == `ACR_OFF_XSEL + 8'(4 * i)) xsel_next[i] = pwdata[4:0];
      end
    end
    // converter on for input ports when forced, or in auto while the input is not locked to the system clock
    for (int p = 0; p < 4; p++) begin
      unique case (acr_src_t'(src_mode_reg[2*p +: 2]))
        SRC_OFF: src_en_next[p] = 1'b0;
        SRC_ON: src_en_next[p] = !aes_dir_reg[p];
        SRC_AUTO, SRC_AUTO_ALT: src_en_next[p] = !aes_dir_reg[p] && !aes_rate_sync[p];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aes_dir_reg <= `ACR_RST_DIR;
      src_mode_reg <= `ACR_RST_SRC;
      track_reg <= 4'h0;
      emb_fb_reg <= FB_MATRIX;
      aes_fb_reg <= 8'h00;
      sine_lvl_reg <= 1'b0;
      rel_dly_reg <= 16'h0000;
      aes_dly_reg <= '{default: 16'h0000};
      xsel_reg <= '{default: `ACR_RST_XSEL};
      shuf_reg <= '{default: `ACR_RST_SHUF};
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      src_en_reg <= 4'h0;
    end else begin
      aes_dir_reg <= aes_dir_next;
      src_mode_reg <= src_mode_next;
      track_reg <= track_next;
      emb_fb_reg <= emb_fb_next;
      aes_fb_reg <= aes_fb_next;
      sine_lvl_reg <= sine_lvl_next;
      rel_dly_reg <= rel_dly_next;
      aes_dly_reg <= aes_dly_next;
      xsel_reg <= xsel_next;
      shuf_reg <= shuf_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      src_en_reg <= src_en_next;
    end
  end

  // ==========================================
  // delay store: one write and five time-shared reads per sample period
  logic [RW-1:0] mem [DEPTH];
  logic [RW-1:0] rd_q, wr_word;
  logic [9:0] phase_reg, phase_next;
  logic [AW-1:0] wptr_reg, wptr_next, rd_addr_reg, rd_addr_next;
  logic [15:0] dly [5];
  logic [16:0] cl [5];
  logic signed [17:0] vsum;
  logic [4*SW-1:0] wa_l, wa_r;

  always_comb begin
    // the measured video delay already includes the N..N+1 frame drift
    vsum = $signed({2'b00, video_delay}) + $signed({{2{rel_dly_reg[15]}}, rel_dly_reg});
    cl[0] = clamp_d(vsum);
    for (int p = 0; p < 4; p++) begin
      if (track_reg[p] && aes_rate_sync[p]) begin
        cl[p+1] = cl[0];
      end else begin
        cl[p+1] = clamp_d($signed({2'b00, aes_dly_reg[p]}));
      end
    end
    for (int t = 0; t < 5; t++) begin
      dly[t] = cl[t][15:0];
      dly_err_next[t] = cl[t][16];
    end
    for (int p = 0; p < 4; p++) begin
      wa_l[p*SW +: SW] = src_en_reg[p] ? aes_src_l[p*SW +: SW] : aes_in_l[p*SW +: SW];
      wa_r[p*SW +: SW] = src_en_reg[p] ? aes_src_r[p*SW +: SW] : aes_in_r[p*SW +: SW];
    end
    // extraction is unconditional: every channel enters the store each sample
    wr_word = {aes_in_valid & ~aes_dir_reg, demb_valid, wa_r, wa_l, demb_data};
    phase_next = (phase_reg == TICK_LAST) ? 10'h0 : phase_reg + 10'h1;
    wptr_next = wptr_reg;
    if (phase_reg == TICK_LAST) begin
      wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
    end
    rd_addr_next = rd_addr_reg;
    for (int t = 0; t < 5; t++) begin
      if (phase_reg == 10'(`ACR_PH_RD0 + t)) rd_addr_next = dly_addr(wptr_reg, dly[t]);
    end
  end

  always_ff @(posedge pclk) begin
    if (phase_reg == 10'h0) mem[wptr_reg] <= wr_word;
    rd_q <= mem[rd_addr_reg];
  end

  // ==========================================
  // taps, tone, crosspoint and fallbacks
  logic [16*SW-1:0] dtap_reg, dtap_next;
  logic [7:0] dval_reg, dval_next;
  logic [SW-1:0] atl_reg [4], atl_next [4], atr_reg [4], atr_next [4];
  logic [3:0] aval_reg, aval_next;
  logic [5:0] sph_reg, sph_next;
  logic [17:0] gap_reg, gap_next;
  logic [4:0] xact_reg [NDST], xact_next [NDST];
  logic [9:0] sact_reg [4], sact_next [4];
  logic [SW-1:0] ms [24], sl [NSRC], sr [NSRC], ol, orr, sine;
  logic mv [24], sv [NSRC], ov;
  logic [3:0] qk;
  logic neg;
  logic signed [32:0] prod;
  logic [8*SW-1:0] emb_l_reg, emb_l_next, emb_r_reg, emb_r_next;
  logic [7:0] emb_v_reg, emb_v_next, emb_d_reg, emb_d_next;
  logic [4*SW-1:0] aol_reg, aol_next, aor_reg, aor_next;
  logic [3:0] aov_reg, aov_next, aoe_reg, aoe_next;
  logic [SW-1:0] dl_reg, dl_next, dr_reg, dr_next;
  logic dv_reg, dv_next, stb_reg, stb_next;
  acr_fb_t fb;

  always_comb begin
    dtap_next = dtap_reg;
    dval_next = dval_reg;
    atl_next = atl_reg;
    atr_next = atr_reg;
    aval_next = aval_reg;
    if (phase_reg == 10'(`ACR_PH_CAP0)) begin
      dtap_next = rd_q[16*SW-1:0];
      dval_next = rd_q[24*SW +: 8];
    end
    for (int p = 0; p < 4; p++) begin
      if (phase_reg == 10'(`ACR_PH_CAP0 + 1 + p)) begin
        atl_next[p] = rd_q[16*SW + p*SW +: SW];
        atr_next[p] = rd_q[20*SW + p*SW +: SW];
        aval_next[p] = rd_q[24*SW + 8 + p];
      end
    end
    // 48 points per tone period, quarter-wave table unfolded by symmetry
    neg = sph_reg > 6'd24;
    if (sph_reg <= 6'd12) qk = sph_reg[3:0];
    else if (sph_reg <= 6'd24) qk = 4'(6'd24 - sph_reg);
    else if (sph_reg <= 6'd36) qk = 4'(sph_reg - 6'd24);
    else qk = 4'(6'd48 - sph_reg);
    prod = $signed(qsin(qk)) * $signed({1'b0, sine_lvl_reg ? `ACR_LVL_20 : `ACR_LVL_18});
    sine = neg ? SW'(-prod[30:7]) : prod[30:7];
    // mono pool: aes L/R by port, then extracted channels
    for (int p = 0; p < 4; p++) begin
      ms[2*p] = atl_reg[p];
      ms[2*p+1] = atr_reg[p];
      mv[2*p] = aval_reg[p];
      mv[2*p+1] = aval_reg[p];
    end
    for (int c = 0; c < 16; c++) begin
      ms[8+c] = dtap_reg[c*SW +: SW];
      mv[8+c] = dval_reg[c/2];
    end
    for (int p = 0; p < 4; p++) begin
      sl[p] = atl_reg[p];
      sr[p] = atr_reg[p];
      sv[p] = aval_reg[p];
    end
    for (int q = 0; q < 8; q++) begin
      sl[4+q] = dtap_reg[2*q*SW +: SW];
      sr[4+q] = dtap_reg[(2*q+1)*SW +: SW];
      sv[4+q] = dval_reg[q];
    end
    sl[12] = (gap_reg < GAP_LEN) ? '0 : sine;
    sr[12] = sine;
    sv[12] = 1'b1;
    sl[13] = '0;
    sr[13] = '0;
    sv[13] = 1'b1;
    for (int m = 0; m < 4; m++) begin
      // out-of-range picks read as invalid silence
      sl[14+m] = (sact_reg[m][4:0] < 5'd24) ? ms[sact_reg[m][4:0]] : '0;
      sr[14+m] = (sact_reg[m][9:5] < 5'd24) ? ms[sact_reg[m][9:5]] : '0;
      sv[14+m] = (sact_reg[m][4:0] < 5'd24) && (sact_reg[m][9:5] < 5'd24) &&
                 mv[sact_reg[m][4:0]] && mv[sact_reg[m][9:5]];
    end
    sph_next = sph_reg;
    gap_next = gap_reg;
    xact_next = xact_reg;
    sact_next = sact_reg;
    emb_l_next = emb_l_reg;
    emb_r_next = emb_r_reg;
    emb_v_next = emb_v_reg;
    emb_d_next = emb_d_reg;
    aol_next = aol_reg;
    aor_next = aor_reg;
    aov_next = aov_reg;
    aoe_next = aoe_reg;
    dl_next = dl_reg;
    dr_next = dr_reg;
    dv_next = dv_reg;
    stb_next = phase_reg == 10'(`ACR_PH_OUT);
    ol = '0;
    orr = '0;
    ov = 1'b0;
    fb = FB_MATRIX;
    if (phase_reg == 10'(`ACR_PH_OUT)) begin
      sph_next = (sph_reg == SINE_LAST) ? 6'h0 : sph_reg + 6'h1;
      gap_next = (gap_reg == CYC_LAST) ? 18'h0 : gap_reg + 18'h1;
      // selections change only here, between whole samples
      xact_next = xsel_reg;
      sact_next = shuf_reg;
      for (int d = 0; d < NDST; d++) begin
        ol = (xact_reg[d] < 5'(NSRC)) ? sl[xact_reg[d]] : '0;
        orr = (xact_reg[d] < 5'(NSRC)) ? sr[xact_reg[d]] : '0;
        ov = (xact_reg[d] < 5'(NSRC)) && sv[xact_reg[d]];
        fb = (d < 8) ? emb_fb_reg : acr_fb_t'(aes_fb_reg[2*(d%4) +: 2]);
        if (!ov && d < 12) begin
          unique case (fb)
            FB_MATRIX: ;
            FB_SINE: begin
              ol = sl[12];
              orr = sr[12];
              ov = 1'b1;
            end
            FB_MUTE: begin
              ol = '0;
              orr = '0;
              ov = 1'b1;
            end
            FB_DELETE: begin
              ol = '0;
              orr = '0;
            end
          endcase
        end
        if (d < 8) begin
          emb_l_next[d*SW +: SW] = ol;
          emb_r_next[d*SW +: SW] = orr;
          emb_v_next[d] = ov;
          emb_d_next[d] = !sv_ok(ov, fb);
        end else if (d < 12) begin
          aol_next[(d-8)*SW +: SW] = ol;
          aor_next[(d-8)*SW +: SW] = orr;
          aov_next[d-8] = ov && aes_dir_reg[d-8];
          aoe_next[d-8] = aes_dir_reg[d-8] && !(!ov && fb == FB_DELETE);
        end else begin
          dl_next = ol;
          dr_next = orr;
          dv_next = ov;
        end
      end
    end
  end

  function automatic logic sv_ok(input logic v, input acr_fb_t f);
    sv_ok = v || f != FB_DELETE;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 10'h0;
      wptr_reg <= '0;
      rd_addr_reg <= '0;
      dly_err_reg <= 5'h0;
      dtap_reg <= '0;
      dval_reg <= 8'h0;
      atl_reg <= '{default: '0};
      atr_reg <= '{default: '0};
      aval_reg <= 4'h0;
      sph_reg <= 6'h0;
      gap_reg <= 18'h0;
      xact_reg <= '{default: `ACR_RST_XSEL};
      sact_reg <= '{default: `ACR_RST_SHUF};
      emb_l_reg <= '0;
      emb_r_reg <= '0;
      emb_v_reg <= 8'h0;
      emb_d_reg <= 8'h0;
      aol_reg <= '0;
      aor_reg <= '0;
      aov_reg <= 4'h0;
      aoe_reg <= 4'h0;
      dl_reg <= '0;
      dr_reg <= '0;
      dv_reg <= 1'b0;
      stb_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      wptr_reg <= wptr_next;
      rd_addr_reg <= rd_addr_next;
      dly_err_reg <= dly_err_next;
      dtap_reg <= dtap_next;
      dval_reg <= dval_next;
      atl_reg <= atl_next;
      atr_reg <= atr_next;
      aval_reg <= aval_next;
      sph_reg <= sph_next;
      gap_reg <= gap_next;
      xact_reg <= xact_next;
      sact_reg <= sact_next;
      emb_l_reg <= emb_l_next;
      emb_r_reg <= emb_r_next;
      emb_v_reg <= emb_v_next;
      emb_d_reg <= emb_d_next;
      aol_reg <= aol_next;
      aor_reg <= aor_next;
      aov_reg <= aov_next;
      aoe_reg <= aoe_next;
      dl_reg <= dl_next;
      dr_reg <= dr_next;
      dv_reg <= dv_next;
      stb_reg <= stb_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign src_en = src_en_reg;
  assign emb_l = emb_l_reg;
  assign emb_r = emb_r_reg;
  assign emb_valid = emb_v_reg;
  assign emb_delete = emb_d_reg;
  assign aes_out_l = aol_reg;
  assign aes_out_r = aor_reg;
  assign aes_out_valid = aov_reg;
  assign aes_oe = aoe_reg;
  assign data_l = dl_reg;
  assign data_r = dr_reg;
  assign data_valid = dv_reg;
  assign smp_strobe = stb_reg;
endmodule

// ---- tb/acr_router_assertions.sv ----
// concurrent checks on the router's ports
// assumes one pclk domain, bound into acr_router
`timescale 1ns/1ps
module acr_chk import acr_pkg::*; #(parameter int SW = 24) (
  // clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // stream side
  input wire logic [8*SW-1:0] emb_l,
  input wire logic [7:0] emb_valid,
  input wire logic [7:0] emb_delete,
  input wire logic smp_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // cycles since last strobe, 0 until the first one
  logic [9:0] gap_reg, gap_next;
  assign gap_next = smp_strobe ? 10'h001 : (gap_reg == 10'h000 ? 10'h000 : gap_reg + 10'h001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= 10'h000;
    else gap_reg <= gap_next;
  end
  // ==========================================
  // properties
  AST_SETUP_READY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
  AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ODD_ADDR: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("odd address accepted");
  AST_RATE: assert property (smp_strobe && gap_reg != 10'h000 |-> gap_reg == 10'h341) else $error("bad period");
  AST_EMB_HOLD: assert property ($changed(emb_l) |-> ##[0:1] smp_strobe) else $error("mid-sample change");
  AST_DEL_INVALID: assert property ((emb_delete & emb_valid) == 8'h00) else $error("deleted but valid");
  AST_DEL_ZERO: assert property (emb_delete[3] |-> emb_l[3*SW+:SW] == {SW{1'b0}}) else $error("deleted not zero");
  cover property (pslverr);
  cover property (emb_delete != 8'h00);
  cover property (smp_strobe && gap_reg == 10'h341);
endmodule
bind acr_router acr_chk #(.SW(SW)) acr_chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .emb_l(emb_l), .emb_valid(emb_valid),
  .emb_delete(emb_delete), .smp_strobe(smp_strobe));

// ---- tb/acr_router_tb_top.sv ----
// self-checking bench for the audio crosspoint router
// assumes acr_src_model as far side and a small store for short runs
`timescale 1ns/1ps
module acr_router_tb_top import acr_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] video_delay = 16'h0000;
  logic [383:0] demb_data;
  logic [191:0] emb_l, emb_r;
  logic [95:0] aes_in_l, aes_in_r, aes_src_l, aes_src_r, aes_out_l, aes_out_r;
  logic [7:0] demb_valid, emb_valid, emb_delete;
  logic [3:0] aes_in_valid, aes_rate_sync, src_en, aes_out_valid, aes_oe;
  logic [23:0] data_l, data_r;
  logic data_valid, smp_strobe;
  int n_errors = 0, tests_run = 0, cyc = 0;
  acr_router #(.DEPTH(16)) acr_router_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .demb_data, .demb_valid, .video_delay, .aes_in_l, .aes_in_r, .aes_in_valid,
    .aes_rate_sync, .aes_src_l, .aes_src_r, .src_en, .emb_l, .emb_r, .emb_valid, .emb_delete, .aes_out_l,
    .aes_out_r, .aes_out_valid, .aes_oe, .data_l, .data_r, .data_valid, .smp_strobe);
  acr_src_model acr_src_model_i (.demb_data, .demb_valid, .aes_in_l, .aes_in_r, .aes_in_valid,
    .aes_rate_sync, .aes_src_l, .aes_src_r);
  always #12.5 pclk = ~pclk;
  // ==========================================
  // bus, compare and closing tasks
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] x);
    bus(1'h0, a, 32'h0);
    chk(n, x, q);
  endtask
  // outputs only settle on strobe edges
  task smp(input int k);
    repeat (k) begin
      @(posedge pclk);
      while (smp_strobe !== 1'h1) @(posedge pclk);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      results();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd("dir", 8'h00, 32'h0);
    rd("srcmode", 8'h04, 32'haa);
    rd("xsel0", 8'h40, 32'hd);
    rd("hole", 8'hfc, 32'h0);
    chk("hole err", 32'h1, {31'h0, e});
    rd("odd", 8'h41, 32'h0);
    bus(1'h1, 8'h00, 32'h1);
    for (int i = 0; i < 13; i++) bus(1'h1, 8'h40 + 8'(4 * i), 32'(4 + i % 8));
    smp(3);
    for (int i = 0; i < 8; i++) begin
      chk("emb_l", 32'(24'h0a0000 + 2 * i), {8'h00, emb_l[i*24+:24]});
      chk("emb_r", 32'(24'h0a0001 + 2 * i), {8'h00, emb_r[i*24+:24]});
    end
    chk("aes out", 32'h0a0000, {8'h00, aes_out_l[23:0]});
    chk("oe", 32'h1, {28'h0, aes_oe});
    chk("data", 32'h0a0008, {8'h00, data_l});
    chk("data r", 32'h0a0009, {8'h00, data_r});
    chk("aes out r", 32'h0a0001, {8'h00, aes_out_r[23:0]});
    chk("out valid", 32'h11, {27'h0, data_valid, aes_out_valid});
    bus(1'h1, 8'h80, 32'h1a2);
    bus(1'h1, 8'h44, 32'he);
    bus(1'h1, 8'h48, 32'h0);
    bus(1'h1, 8'h4c, 32'h14);
    for (int f = 0; f < 4; f++) begin
      bus(1'h1, 8'h0c, 32'(f));
      smp(3);
      chk("valid", 32'(f == 1 || f == 2), {31'h0, emb_valid[3]});
      chk("outport src", 32'(f == 1 || f == 2), {31'h0, emb_valid[2]});
      chk("delete", 32'(f == 3), {31'h0, emb_delete[3]});
      if (f == 2) chk("mute", 32'h0, {8'h00, emb_l[95:72]});
    end
    chk("shuf l", 32'h0b0002, {8'h00, emb_l[47:24]});
    chk("shuf r", 32'h0a0005, {8'h00, emb_r[47:24]});
    bus(1'h1, 8'h60, 32'h14);
    bus(1'h1, 8'h0c, 32'hf);
    rd("fb", 8'h0c, 32'hf);
    bus(1'h1, 8'h04, 32'h4);
    smp(3);
    chk("oe off", 32'h0, {28'h0, aes_oe});
    chk("src", 32'h2, {28'h0, src_en});
    bus(1'h1, 8'h14, 32'hffff);
    smp(1);
    rd("st", 8'h28, 32'h12);
    chk("neg clamp", 32'h1, {31'h0, q[4]});
    video_delay <= 16'h0064;
    bus(1'h1, 8'h14, 32'h0);
    smp(1);
    rd("st", 8'h28, 32'h12);
    chk("depth clamp", 32'h1, {31'h0, q[4]});
    video_delay <= 16'h0010;
    bus(1'h1, 8'h14, 32'hfff8);
    smp(1);
    rd("st", 8'h28, 32'h2);
    chk("in range", 32'h0, {31'h0, q[4]});
    results();
  end
endmodule

// ---- tb/acr_src_model.sv ----
// far-side model: de-embedder and aes receivers feeding the router
// assumes a steady 48 kHz system-locked source, every channel present
`timescale 1ns/1ps
module acr_src_model import acr_pkg::*; #(parameter int SW = 24) (
  // de-embedded audio
  output logic [16*SW-1:0] demb_data,
  output logic [7:0] demb_valid,
  // aes receivers and rate converters
  output logic [4*SW-1:0] aes_in_l,
  output logic [4*SW-1:0] aes_in_r,
  output logic [3:0] aes_in_valid,
  output logic [3:0] aes_rate_sync,
  output logic [4*SW-1:0] aes_src_l,
  output logic [4*SW-1:0] aes_src_r
);
  // ==========================================
  // constant tags per channel so routing errors show as wrong tags
  always_comb begin
    demb_valid = 8'hff;
    aes_in_valid = 4'hf;
    aes_rate_sync = 4'hf;
    for (int c = 0; c < 16; c++) demb_data[c*SW+:SW] = SW'(24'h0a0000 + c);
    for (int p = 0; p < 4; p++) begin
      aes_in_l[p*SW+:SW] = SW'(24'h0b0000 + 2 * p);
      aes_in_r[p*SW+:SW] = SW'(24'h0b0001 + 2 * p);
      aes_src_l[p*SW+:SW] = SW'(24'h0c0000 + 2 * p);
      aes_src_r[p*SW+:SW] = SW'(24'h0c0001 + 2 * p);
    end
  end
endmodule
